/* hw/lpd_crc8.sv */
`timescale 1ns/1ps
`include "lpd_defs.svh"
module lpd_crc8 (
   input  wire logic [23:0] data_i, // Command byte and data word.
   output logic      [7:0]  crc_o   // CRC over the 24 bits, MSB first.
);
   logic [7:0] c;
   integer     i;

   // Bitwise CRC-8, unrolled by the loop; cheap since it runs once per frame.
   always_comb begin
      c = 8'h00;
      for (i = 23; i >= 0; i = i - 1) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ data_i[i]) ? `LPD_CRC_POLY : 8'h00);
      end
      crc_o = c;
   end
endmodule

/* hw/lpd_ctrl.sv */
// Functional notes
// (RULE_01) Set auto-readback-off before reading other registers.
// (RULE_02) Data word of read frames is ignored.
// (RULE_03) Read data shifts out in next frame.
// (RULE_04) MSB first: command, data, optional CRC.
// (RULE_05) Output code register is read/write, sets target.
// (RULE_06) Target is range low plus code times span.
// (RULE_07) Timeout select picks 50 ms to 5 s.
// (RULE_08) Valid writes and no-op restart watchdog.
// (RULE_09) Fault word shifts out unless auto-readback off.
// (RULE_10) Watchdog timeout sets D15, may force alarm.
// (RULE_11) CRC failure sets flag and fault output.
// (RULE_12) Current high/low flags assert fault output.
// (RULE_13) Hot flag follows comparator, asserts fault.
// (RULE_14) Warm flag follows comparator, no fault output.
// (RULE_15) Loop low flag may assert fault output.
// (RULE_16) Loop warning flag never asserts fault output.
// (RULE_17) Low byte holds latest measurement, source selectable.
// (RULE_18) Measurement code scaling is analog side.
// (RULE_19) Measurement converter off after reset.
// (RULE_20) Reference powered after reset, down when set.
// (RULE_21) Trims take effect on next code write.
// (RULE_22) Zero trim is code minus 32768.
// (RULE_23) Span trim reduces full scale by 65535-code.
// (RULE_24) Decode write, action and read command codes.
// (RULE_25) Capture on clock fall, act on select rise.
// (RULE_26) Reserved configuration bits read as zero.
// (RULE_27) Watchdog counts a timebase from system clock.
`timescale 1ns/1ps
`include "lpd_defs.svh"
module lpd_ctrl #(
   parameter int WD_TICK_CYC = `LPD_TICK_CYC     // Cycles per watchdog ms tick.
) (
   input  wire logic        clk_sys_i,           // System clock, 40 MHz.
   input  wire logic        rst_n_i,             // Synchronous reset, active low.
   input  wire logic        sclk_i,              // Serial clock pin.
   input  wire logic        sync_n_i,            // Frame select pin, active low.
   input  wire logic        serial_in_i,         // Serial data in.
   output logic             serial_out_o,        // Serial data out.
   input  wire logic        alarm_dir_i,         // Alarm direction pin, 1 = upscale.
   input  wire logic        current_high_flag_i, // Loop current above target.
   input  wire logic        current_low_flag_i,  // Loop current below target.
   input  wire logic        temp_hot_i,          // Die over-temperature comparator.
   input  wire logic        temp_warm_i,         // Die warning comparator.
   input  wire logic        loop_voltage_sense_low_i,         // Loop sense below low threshold.
   input  wire logic        loop_voltage_sense_warn_i,        // Loop sense below warning threshold.
   input  wire logic [7:0]  meas_code_i,         // Measurement converter result.
   input  wire logic        meas_done_i,         // Measurement result ready level.
   output logic             fault_o,             // Fault pin, active high.
   output logic             alarm_force_o,       // Force alarm current.
   output logic             alarm_upscale_o,     // Alarm direction, 1 = upscale.
   output logic [15:0]      out_code_o,          // Applied output code.
   output logic [15:0]      out_zero_o,          // Applied zero trim.
   output logic [15:0]      out_span_o,          // Applied span trim.
   output logic             min_current_o,       // Set minimum loop current.
   output logic             meas_sel_o,          // 1 = die temperature source.
   output logic             meas_en_o,           // Measurement converter enable.
   output logic             meas_start_o,        // Start measurement pulse.
   output logic             ref_pd_o             // Power down internal reference.
);
   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   localparam int NSYNC = 19;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync_m_r;
   logic [NSYNC-1:0] sync_s_r;
   logic             sclk_d_r;
   logic             sync_d_r;
   logic             done_d_r;

   assign async_in = {meas_code_i, meas_done_i, loop_voltage_sense_warn_i, loop_voltage_sense_low_i, temp_warm_i,
                      temp_hot_i, current_low_flag_i, current_high_flag_i, alarm_dir_i,
                      serial_in_i, sync_n_i, sclk_i};

   // Two flops per pin; only the second stage is used by any logic.
   // Reset parks each stage at its pin's idle level (select high), so that no
   // false select edge, and with it no stray frame start, follows reset.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               sync_m_r[gi] <= (gi == 1) ? 1'b1 : 1'b0;
               sync_s_r[gi] <= (gi == 1) ? 1'b1 : 1'b0;
            end else begin
               sync_m_r[gi] <= async_in[gi];
               sync_s_r[gi] <= sync_m_r[gi];
            end
         end
      end
   endgenerate

   logic       sclk_s, sync_s, serial_in_s, dir_s, hi_s, lo_s, hot_s, warm_s;
   logic       vlow_s, vwarn_s, done_s;
   logic [7:0] code_s;
   assign {code_s, done_s, vwarn_s, vlow_s, warm_s, hot_s, lo_s, hi_s, dir_s, serial_in_s,
           sync_s, sclk_s} = sync_s_r;

   // Delayed copies for edge detection; select idles high.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sclk_d_r <= 1'b0;
         sync_d_r <= 1'b1;
         done_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         sync_d_r <= sync_s;
         done_d_r <= done_s;
      end
   end

   logic sclk_fall, sclk_rise, sync_fall, sync_rise;
   assign sclk_fall = sclk_d_r & ~sclk_s;
   assign sclk_rise = ~sclk_d_r & sclk_s;
   assign sync_fall = sync_d_r & ~sync_s;
   assign sync_rise = ~sync_d_r & sync_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame capture.
   lpd_pkg::lpd_link_t link_st_r;
   logic [31:0]        in_sh_r;
   logic [5:0]         bit_cnt_r;
   logic [23:0]        out_sh_r;

   // Framing state follows the select line.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) link_st_r <= lpd_pkg::LNK_IDLE;
      else begin
         case (link_st_r)
            lpd_pkg::LNK_IDLE:  if (sync_fall) link_st_r <= lpd_pkg::LNK_SHIFT;
            lpd_pkg::LNK_SHIFT: if (sync_rise) link_st_r <= lpd_pkg::LNK_IDLE;
            default:            link_st_r <= lpd_pkg::LNK_IDLE;
         endcase
      end
   end

   // Bits enter MSB first on falling serial clock; count saturates past 32.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         in_sh_r   <= 32'h00000000;
         bit_cnt_r <= 6'h00;
      end else if (sync_fall) begin
         bit_cnt_r <= 6'h00;
      end else if (link_st_r == lpd_pkg::LNK_SHIFT && sclk_fall) begin
         in_sh_r <= {in_sh_r[30:0], serial_in_s}; // RULE_25
         if (bit_cnt_r != 6'h21) bit_cnt_r <= bit_cnt_r + 6'h01;
      end
   end

   // A frame counts only at exactly 24 or 32 bits; the longer one carries CRC.
   logic        frm_go, frm_ok, crc_bad, is_crc;
   logic [23:0] frm_word;
   logic [7:0]  frm_cmd, crc_calc;
   logic [15:0] frm_data;
   assign is_crc   = (bit_cnt_r == `LPD_FRAME_CRC);
   assign frm_go   = sync_rise && link_st_r == lpd_pkg::LNK_SHIFT &&
                     (is_crc || bit_cnt_r == `LPD_FRAME_SHORT);
   assign frm_word = is_crc ? in_sh_r[31:8] : in_sh_r[23:0]; // RULE_04
   assign frm_cmd  = frm_word[23:16];
   assign frm_data = frm_word[15:0];
   assign crc_bad  = frm_go && is_crc && (crc_calc != in_sh_r[7:0]); // RULE_11
   assign frm_ok   = frm_go && !crc_bad;

   lpd_crc8 u_crc (
      .data_i (in_sh_r[31:8]),
      .crc_o  (crc_calc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode.
   logic cmd_wr, cmd_rd, kick, soft_rst, rst_all;
   assign cmd_wr = frm_ok && frm_cmd >= `LPD_CMD_WR_CODE &&
                   frm_cmd <= `LPD_CMD_WR_SPAN; // RULE_24 RULE_02
   assign cmd_rd = frm_ok && frm_cmd >= `LPD_CMD_RD_CODE && frm_cmd <= `LPD_CMD_RD_FAULT;
   assign kick   = cmd_wr || (frm_ok && frm_cmd == `LPD_CMD_NOP); // RULE_08
   assign soft_rst = frm_ok && frm_cmd == `LPD_CMD_RESET;
   assign rst_all  = !rst_n_i || soft_rst;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [15:0] code_r, cfg_r, zero_r, span_r, fault_word;
   logic        apply;
   assign apply = frm_ok && (frm_cmd == `LPD_CMD_WR_CODE || frm_cmd == `LPD_CMD_LOAD);

   // Output code; read frames never reach here so their data is dropped.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) code_r <= `LPD_CODE_RST;
      else if (frm_ok && frm_cmd == `LPD_CMD_WR_CODE) code_r <= frm_data; // RULE_05
   end

   // Configuration; reserved low bits are never stored.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) cfg_r <= `LPD_CFG_RST; // RULE_19 RULE_20
      else if (frm_ok && frm_cmd == `LPD_CMD_WR_CFG)
         cfg_r <= frm_data & `LPD_CFG_WMASK; // RULE_26
   end

   // Trim registers are only staged here.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) begin
         zero_r <= `LPD_ZERO_RST; // RULE_22
         span_r <= `LPD_SPAN_RST; // RULE_23
      end else begin
         if (frm_ok && frm_cmd == `LPD_CMD_WR_ZERO) zero_r <= frm_data;
         if (frm_ok && frm_cmd == `LPD_CMD_WR_SPAN) span_r <= frm_data;
      end
   end

   // Staged trims reach the analog side only with a code write or load.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) begin
         out_code_o <= `LPD_CODE_RST;
         out_zero_o <= `LPD_ZERO_RST;
         out_span_o <= `LPD_SPAN_RST;
      end else if (apply) begin
         out_code_o <= (frm_cmd == `LPD_CMD_WR_CODE) ? frm_data : code_r; // RULE_06
         out_zero_o <= zero_r; // RULE_21
         out_span_o <= span_r; // RULE_21
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog and alarm.
   logic wd_fault, alarm_cmd_r;

   lpd_wdog #(
      .TICK_CYC (WD_TICK_CYC)
   ) u_wdog (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (~rst_all),
      .en_i      (cfg_r[`LPD_CFG_WD_EN]),
      .sel_i     (cfg_r[`LPD_CFG_TMO_HI:`LPD_CFG_TMO_LO]),
      .kick_i    (kick),
      .expired_o (wd_fault)
   );

   // Alarm holds from reset until the first code is applied, as after power-up.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) alarm_cmd_r <= 1'b1;
      else if (frm_ok && frm_cmd == `LPD_CMD_ALARM) alarm_cmd_r <= 1'b1;
      else if (apply) alarm_cmd_r <= 1'b0;
   end

   assign alarm_force_o   = alarm_cmd_r || (wd_fault && !cfg_r[`LPD_CFG_NO_ALARM]); // RULE_10
   assign alarm_upscale_o = dir_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Fault and measurement.
   logic       crc_error_flag_r, fault_load;
   logic [7:0] meas_r;

   // Sticky CRC flag cleared when the fault word loads at select fall; a new error in that cycle wins.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) crc_error_flag_r <= 1'b0;
      else if (crc_bad) crc_error_flag_r <= 1'b1; // RULE_11
      else if (fault_load) crc_error_flag_r <= 1'b0;
   end

   // Latest measurement, taken on the rising ready level while enabled.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) meas_r <= 8'h00;
      else if (done_s && !done_d_r && cfg_r[`LPD_CFG_MEAS_EN]) meas_r <= code_s; // RULE_17
   end

   assign fault_word = {wd_fault, crc_error_flag_r, hi_s, lo_s, hot_s, warm_s, vlow_s,
                        vwarn_s, meas_r}; // RULE_12 RULE_13 RULE_14 RULE_15 RULE_16 RULE_18
   // Warning-level flags are left out of the pin on purpose.
   assign fault_o = wd_fault | crc_error_flag_r | hi_s | lo_s | hot_s |
                    (vlow_s & cfg_r[`LPD_CFG_LOW_ALRT]); // RULE_15 RULE_16 RULE_14

   assign min_current_o = cfg_r[`LPD_CFG_MIN_I];
   assign meas_sel_o    = cfg_r[`LPD_CFG_MEAS_SEL]; // RULE_17
   assign meas_en_o     = cfg_r[`LPD_CFG_MEAS_EN]; // RULE_19
   assign ref_pd_o      = cfg_r[`LPD_CFG_REF_PD]; // RULE_20

   // One-cycle start request for the measurement converter.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) meas_start_o <= 1'b0;
      else meas_start_o <= frm_ok && frm_cmd == `LPD_CMD_MEAS && cfg_r[`LPD_CFG_MEAS_EN];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Readback.
   logic        rd_pend_r;
   logic [2:0]  rd_sel_r;
   logic [15:0] rd_data;

   // A read only records its target; the data leaves in the next frame.
   always_ff @(posedge clk_sys_i) begin
      if (rst_all) begin
         rd_pend_r <= 1'b0;
         rd_sel_r  <= 3'h0;
      end else if (cmd_rd) begin
         rd_pend_r <= 1'b1; // RULE_03
         rd_sel_r  <= frm_cmd[2:0];
      end else if (sync_fall) rd_pend_r <= 1'b0;
   end

   always_comb begin
      case (rd_sel_r)
         3'h1:    rd_data = code_r;
         3'h2:    rd_data = cfg_r;
         3'h3:    rd_data = zero_r;
         3'h4:    rd_data = span_r;
         default: rd_data = fault_word;
      endcase
   end

   // Pending read beats the automatic fault word, which the host must turn off
   // to avoid confusion on a stream of writes.
   assign fault_load = sync_fall && (rd_pend_r ? (rd_sel_r == 3'h5)
                                               : !cfg_r[`LPD_CFG_NO_AUTO]);

   // Word loads at select fall, then moves on each rising serial clock.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) out_sh_r <= 24'h000000;
      else if (sync_fall) begin
         if (rd_pend_r) out_sh_r <= {rd_data, 8'h00}; // RULE_01 RULE_03
         else if (!cfg_r[`LPD_CFG_NO_AUTO]) out_sh_r <= {fault_word, 8'h00}; // RULE_09
         else out_sh_r <= 24'h000000;
      end else if (link_st_r == lpd_pkg::LNK_SHIFT && sclk_rise)
         out_sh_r <= {out_sh_r[22:0], 1'b0};
   end

   assign serial_out_o = out_sh_r[23];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   AST_RD_DATA_IGNORED: assert property (cmd_rd |=> $stable(code_r) && $stable(cfg_r)) // RULE_02
      else $error("Read frame altered a register.");
   AST_CODE_WRITE: assert property ( // RULE_05
      frm_ok && frm_cmd == `LPD_CMD_WR_CODE |=> code_r == $past(frm_data) &&
      out_code_o == $past(frm_data) && (!alarm_force_o || wd_fault))
      else $error("Code write not applied.");
   AST_WD_KICK: assert property (kick |=> !wd_fault [*2]) // RULE_08
      else $error("Watchdog not restarted by valid frame.");
   AST_CRC_FLAG: assert property (crc_bad |=> crc_error_flag_r && fault_o) // RULE_11
      else $error("CRC error not flagged.");
   AST_CURRENT_FAULT: assert property ((hi_s || lo_s || hot_s) |-> fault_o) // RULE_12
      else $error("Current or temperature fault missing on pin.");
   AST_WARN_QUIET: assert property ( // RULE_14
      !(wd_fault || crc_error_flag_r || hi_s || lo_s || hot_s || vlow_s) |-> !fault_o)
      else $error("Warning flag drove fault pin.");
   AST_ALARM: assert property (wd_fault && !cfg_r[`LPD_CFG_NO_ALARM] |-> alarm_force_o) // RULE_10
      else $error("Watchdog timeout without alarm.");
   AST_TRIM_HOLD: assert property ( // RULE_21
      frm_ok && frm_cmd == `LPD_CMD_WR_ZERO |=> $stable(out_zero_o) ##1 $stable(out_zero_o))
      else $error("Zero trim applied without code write.");
   AST_AUTO_RB: assert property ( // RULE_09
      sync_fall && !rd_pend_r && !cfg_r[`LPD_CFG_NO_AUTO] |=>
      out_sh_r == {$past(fault_word), 8'h00})
      else $error("Fault word not loaded for readback.");
   AST_RSVD_ZERO: assert property (cfg_r[4:0] == 5'h00) // RULE_26
      else $error("Reserved configuration bits set.");

   COV_CRC_FRAME: cover property (frm_ok && is_crc);
   COV_READBACK: cover property (cmd_rd ##[1:1000] sync_fall && rd_pend_r);
   COV_WD_ALARM: cover property (wd_fault && alarm_force_o);
endmodule

/* hw/lpd_defs.svh */
`ifndef LPD_DEFS_SVH
`define LPD_DEFS_SVH
// Command byte codes.
`define LPD_CMD_WR_CODE  8'h01
`define LPD_CMD_WR_CFG   8'h02
`define LPD_CMD_WR_ZERO  8'h03
`define LPD_CMD_WR_SPAN  8'h04
`define LPD_CMD_LOAD     8'h05
`define LPD_CMD_ALARM    8'h06
`define LPD_CMD_RESET    8'h07
`define LPD_CMD_MEAS     8'h08
`define LPD_CMD_NOP      8'h09
`define LPD_CMD_RD_CODE  8'h81
`define LPD_CMD_RD_CFG   8'h82
`define LPD_CMD_RD_ZERO  8'h83
`define LPD_CMD_RD_SPAN  8'h84
`define LPD_CMD_RD_FAULT 8'h85
// Register reset values and configuration write mask.
`define LPD_CODE_RST     16'h0000
`define LPD_CFG_RST      16'h7000
`define LPD_ZERO_RST     16'h8000
`define LPD_SPAN_RST     16'hFFFF
`define LPD_CFG_WMASK    16'hFFE0
// Configuration field positions.
`define LPD_CFG_TMO_HI   15
`define LPD_CFG_TMO_LO   13
`define LPD_CFG_WD_EN    12
`define LPD_CFG_NO_AUTO  11
`define LPD_CFG_NO_ALARM 10
`define LPD_CFG_MIN_I    9
`define LPD_CFG_MEAS_SEL 8
`define LPD_CFG_MEAS_EN  7
`define LPD_CFG_REF_PD   6
`define LPD_CFG_LOW_ALRT 5
// Frame lengths and CRC polynomial.
`define LPD_FRAME_SHORT  6'd24
`define LPD_FRAME_CRC    6'd32
`define LPD_CRC_POLY     8'h07
// Timing: clock period and watchdog timebase tick, in ns.
`define LPD_CLK_NS       25
`define LPD_TICK_NS      1000000
`define LPD_TICK_CYC     (`LPD_TICK_NS / `LPD_CLK_NS)
// Watchdog periods in ms.
`define LPD_WD_MS0       13'd50
`define LPD_WD_MS1       13'd100
`define LPD_WD_MS2       13'd500
`define LPD_WD_MS3       13'd1000
`define LPD_WD_MS4       13'd2000
`define LPD_WD_MS5       13'd3000
`define LPD_WD_MS6       13'd4000
`define LPD_WD_MS7       13'd5000
`endif

/* hw/lpd_pkg.sv */
package lpd_pkg;
   // Serial port framing state.
   typedef enum logic [0:0] {LNK_IDLE, LNK_SHIFT} lpd_link_t;
   typedef logic [15:0] lpd_word_t;
endpackage

/* hw/lpd_wdog.sv */
`timescale 1ns/1ps
`include "lpd_defs.svh"
module lpd_wdog #(
   parameter int TICK_CYC = `LPD_TICK_CYC    // Clock cycles per 1 ms tick.
) (
   input  wire logic       clk_sys_i, // System clock.
   input  wire logic       rst_n_i,   // Synchronous reset, active low.
   input  wire logic       en_i,      // Watchdog enable.
   input  wire logic [2:0] sel_i,     // Timeout select.
   input  wire logic       kick_i,    // Valid communication seen.
   output logic            expired_o  // Timeout elapsed, held until kick, reset or disable.
);
   logic [15:0] tick_cnt_r;
   logic [12:0] ms_cnt_r;
   logic [12:0] per_ms;
   logic        tick;

   // Period table; a larger select gives a longer wait.
   always_comb begin
      case (sel_i)
         3'h0:    per_ms = `LPD_WD_MS0;
         3'h1:    per_ms = `LPD_WD_MS1;
         3'h2:    per_ms = `LPD_WD_MS2;
         3'h3:    per_ms = `LPD_WD_MS3;
         3'h4:    per_ms = `LPD_WD_MS4;
         3'h5:    per_ms = `LPD_WD_MS5;
         3'h6:    per_ms = `LPD_WD_MS6;
         default: per_ms = `LPD_WD_MS7;
      endcase
   end

   assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

   // Millisecond timebase from the system clock.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || kick_i || !en_i) tick_cnt_r <= 16'h0000; // RULE_27
      else if (tick) tick_cnt_r <= 16'h0000;
      else tick_cnt_r <= tick_cnt_r + 16'h0001;
   end

   // Elapsed ms; the count stops once the flag is up.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || kick_i || !en_i) ms_cnt_r <= 13'h0000; // RULE_08
      else if (tick && !expired_o) ms_cnt_r <= ms_cnt_r + 13'h0001;
   end

   // Flag rises once the selected period has fully passed.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || kick_i || !en_i) expired_o <= 1'b0;
      else if (ms_cnt_r >= per_ms) expired_o <= 1'b1; // RULE_07
   end
endmodule

/* verif/lpd_ctrl_tb.sv */
`timescale 1ns/1ps
module lpd_ctrl_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sclk, sync_n, sdi, serial_out, fault, a_force, a_up;
   logic        min_i, m_sel, m_en, m_start, ref_pd;
   logic        a_dir = 1'b0;
   logic        m_done = 1'b0;
   logic [5:0]  flg = 6'h00;
   wire         f_hi, f_lo, f_hot, f_warm, f_vlow, f_vwarn;
   // Each flag pin gets its own net, driven from the scenario's flag word.
   assign {f_hi, f_lo, f_hot, f_warm, f_vlow, f_vwarn} = flg;
   logic [7:0]  m_code = 8'h00;
   logic [15:0] code, zero, span;
   logic [23:0] rx;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          starts = 0;
   // Free-running 40 MHz clock.
   always #12.5 clk = ~clk;
   // Count measurement start pulses; each one stands a single cycle.
   always @(negedge clk) if (m_start === 1'b1) starts++;
   // Small tick keeps the 50 ms watchdog at 200 clocks.
   lpd_ctrl #(.WD_TICK_CYC(4)) dut (.clk_sys_i(clk), .rst_n_i(rst_n), .sclk_i(sclk),
      .sync_n_i(sync_n), .serial_in_i(sdi), .serial_out_o(serial_out), .alarm_dir_i(a_dir),
      .current_high_flag_i(f_hi), .current_low_flag_i(f_lo), .temp_hot_i(f_hot),
      .temp_warm_i(f_warm), .loop_voltage_sense_low_i(f_vlow), .loop_voltage_sense_warn_i(f_vwarn),
      .meas_code_i(m_code), .meas_done_i(m_done), .fault_o(fault),
      .alarm_force_o(a_force), .alarm_upscale_o(a_up), .out_code_o(code),
      .out_zero_o(zero), .out_span_o(span), .min_current_o(min_i), .meas_sel_o(m_sel),
      .meas_en_o(m_en), .meas_start_o(m_start), .ref_pd_o(ref_pd));
   lpd_host host (.clk_sys_i(clk), .sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi),
      .sdo_i(serial_out));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Bench copy of the frame check: poly 0x07, init 0, MSB first.
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      host.xfer({8'h00, cmd, d}, 24, 0, rx);
   endtask
   task automatic t_reset;
      chk({8'h00, code}, 24'h000000);
      chk({zero, span[7:0]}, 24'h8000FF);
      chk({18'h0, a_force, fault, m_en, ref_pd, min_i, m_sel}, 24'h000020);
   endtask
   task automatic t_code_trim;
      wr(8'h01, 16'h1234);
      chk(rx, 24'h000000);
      chk({7'h0, a_force, code}, 24'h001234);
      wr(8'h03, 16'h8100);
      wr(8'h04, 16'hF000);
      chk({zero, span[15:8]}, 24'h8000FF);
      wr(8'h01, 16'h4000);
      chk({zero, span[15:8]}, 24'h8100F0);
      wr(8'h06, 16'h0000);
      chk({23'h0, a_force}, 24'h000001);
      wr(8'h05, 16'hFFFF);
      chk({7'h0, a_force, code}, 24'h004000);
   endtask
   // The read frame carries a data word that must change nothing.
   task automatic t_cfg_read;
      wr(8'h02, 16'h7BDF);
      chk({20'h0, min_i, m_sel, m_en, ref_pd}, 24'h00000F);
      host.xfer({8'h00, 24'h82FFFF}, 24, 3, rx);
      wr(8'h09, 16'h0000);
      chk(rx, 24'h7BC000);
      wr(8'h83, 16'h0000);
      wr(8'h09, 16'h0000);
      chk(rx, 24'h810000);
   endtask
   task automatic t_crc;
      host.xfer({24'h015555, crc8(24'h015555)}, 32, 0, rx);
      chk({8'h00, code}, 24'h005555);
      host.xfer({24'h01AAAA, ~crc8(24'h01AAAA)}, 32, 0, rx);
      chk({7'h0, fault, code}, 24'h015555);
      wr(8'h85, 16'h0000);
      wr(8'h09, 16'h0000);
      chk({rx[23:1], fault}, 24'h400000);
   endtask
   // One flag at a time; only some of them may raise the fault pin.
   task automatic t_flags;
      for (int i = 0; i < 6; i++) begin
         flg = 6'h01 << i;
         host.cyc(6);
         chk({23'h0, fault}, {23'h0, i > 2});
      end
      wr(8'h02, 16'h7BE0);
      flg = 6'h02;
      host.cyc(6);
      chk({23'h0, fault}, 24'h000001);
      flg = 6'h00;
      wr(8'h08, 16'h0000);
      chk(starts, 1);
      m_code = 8'hA5;
      m_done = 1'b1;
      host.cyc(6);
      wr(8'h85, 16'h0000);
      wr(8'h09, 16'h0000);
      chk(rx, 24'h00A500);
   endtask
   task automatic t_wdog(input logic [2:0] sel, input int ms);
      int n;
      wr(8'h02, {sel, 13'h1800});
      for (n = 0; n < 30000 && fault !== 1'b1; n++) host.cyc(1);
      if (n == 30000) begin
         chk(0, 1);
         test_done();
      end
      chk({22'h0, n > ms * 4 - 16, n < ms * 4 + 8}, 24'h000003);
      chk({22'h0, a_force, a_up}, {22'h0, 1'b1, a_dir});
      wr(8'h09, 16'h0000);
      chk({23'h0, fault}, 24'h000000);
      wr(8'h01, 16'h1111);
      chk({23'h0, a_force}, 24'h000000);
   endtask
   // Reset, then the scenarios in order; a soft reset closes the run.
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      host.cyc(2);
      t_reset();
      t_code_trim();
      t_cfg_read();
      t_crc();
      t_flags();
      t_wdog(3'h0, 50);
      a_dir = 1'b1;
      t_wdog(3'h7, 5000);
      wr(8'h07, 16'h0000);
      t_reset();
      test_done();
   end
endmodule

/* verif/lpd_host.sv */
`timescale 1ns/1ps
// Host end of the serial port. The clock stands low between frames.
// Outside a frame the data line shows the inverse of its last bit,
// so a stale value is never mistaken for good data.
module lpd_host (
   input  wire logic clk_sys_i, // System clock.
   output logic      sclk_o,    // Serial clock.
   output logic      sync_n_o,  // Frame select, active low.
   output logic      sdi_o,     // Serial data to the device.
   input  wire logic sdo_i      // Serial data from the device.
);
   // Idle levels from time zero.
   initial begin
      sclk_o = 1'b0;
      sync_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // Wait n clocks, then step just past the edge.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // One frame, MSB first; slow stretches both clock phases.
   task automatic xfer(input logic [31:0] w, input int n, input int slow,
                       output logic [23:0] rx);
      rx = 24'h000000;
      sync_n_o = 1'b0;
      cyc(6);
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o = w[i];
         if (i >= n - 24) rx[i - n + 24] = sdo_i;
         sclk_o = 1'b1;
         cyc(4 + slow);
         sclk_o = 1'b0;
         cyc(4 + slow);
      end
      sync_n_o = 1'b1;
      sdi_o = ~sdi_o;
      cyc(8);
   endtask
endmodule
